/* core/gtc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gtc_pin_sync
  import gtc_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire logic [PIN_N-1:0] pinIn,
  output logic      [PIN_N-1:0] pinOut
);
  genvar i;
  generate
    for (i = 0; i < PIN_N; i++) begin : g_pin
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic filt_r;
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_r   <= 1'b0;
          s2_r   <= 1'b0;
          s3_r   <= 1'b0;
          filt_r <= 1'b0;
        end else if (clk_en) begin
          s1_r <= pinIn[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // A change is taken once stages two and three agree
          if (s2_r == s3_r) begin
            filt_r <= s3_r;
          end
        end
      end
      assign pinOut[i] = filt_r;
    end
  endgenerate
endmodule
`default_nettype wire

/* core/gtc_pkg.sv */
// Constants, register map and types of the gated 16-bit timer counter
package gtc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_COUNT_LOW  = 8'h00;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFF_PERIPH_FLG = 8'h08;
  localparam logic [7:0] OFF_PERIPH_ENA = 8'h0c;
  localparam logic [7:0] OFF_COUNT_CTL  = 8'h10;
  localparam logic [7:0] OFF_CMP2_CTLB  = 8'h14;
  localparam logic [7:0] OFF_INTR_CTL   = 8'h18;
  // Field positions of counter_control
  localparam int CTL_RUN      = 0;
  localparam int CTL_CLK_SRC  = 1;
  localparam int CTL_SYNC_DIS = 2;
  localparam int CTL_LP_OSC   = 3;
  localparam int CTL_PS_LO    = 4;
  localparam int CTL_PS_HI    = 5;
  localparam int CTL_GATE_EN  = 6;
  localparam int CTL_GATE_INV = 7;
  // Other field positions
  localparam int FLG_ROLLOVER = 0;
  localparam int ENA_ROLLOVER = 0;
  localparam int INTC_PERIPH  = 6;
  localparam int INTC_GLOBAL  = 7;
  localparam int CMP2_GATE_SS = 1;
  // Reset values
  localparam logic [7:0]  CTL_RST   = 8'h00;
  localparam logic [7:0]  CMP2_RST  = 8'h02;
  localparam logic [7:0]  INTC_RST  = 8'h00;
  localparam logic [7:0]  ENA_RST   = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // Instruction cycle is the system clock divided by four
  localparam int         INSTR_DIV  = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
  // Pins passed through the input synchroniser
  localparam int PIN_EXT  = 0;
  localparam int PIN_LP   = 1;
  localparam int PIN_GATE = 2;
  localparam int PIN_CMP2 = 3;
  localparam int PIN_N    = 4;
  // Arming of external edge counting
  typedef enum logic [0:0] {
    ARM_WAIT  = 1'b0,
    ARM_READY = 1'b1
  } gtc_arm_t;
endpackage

/* core/gtc_prescaler.sv */
// Prescaler dividing the qualified count ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
`default_nettype none
module gtc_prescaler
  import gtc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  gtc_psc_if.psc    psc
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] mask;

  function automatic logic [2:0] ratioMask(input logic [1:0] r);
    case (r)
      2'b00:   ratioMask = 3'h0;
      2'b01:   ratioMask = 3'h1;
      2'b10:   ratioMask = 3'h3;
      default: ratioMask = 3'h7;
    endcase
  endfunction

  assign mask      = ratioMask(psc.ratio);
  assign psc.pulse = psc.tick & ((cnt_r & mask) == mask);
  assign cnt_nxt   = psc.clr ? 3'h0 : (psc.pulse ? 3'h0 : (psc.tick ? cnt_r + 3'h1 : cnt_r));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 3'h0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

/* core/gtc_psc_if.sv */
// Carrier between the counter core and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface gtc_psc_if;
  logic       tick;
  logic       clr;
  logic [1:0] ratio;
  logic       pulse;
  modport core (output tick, output clr, output ratio, input pulse);
  modport psc  (input tick, input clr, input ratio, output pulse);
endinterface
`default_nettype wire

/* core/gtc_timer.sv */
// Gated 16-bit timer counter with AHB-Lite register slave
// How it works
// - Count high and low bytes as one 16-bit value, wrapping all-ones to zero.
// - Every wrap sets the rollover flag, bit 0 of the peripheral flags.
// - Rollover interrupt needs rollover, peripheral and global enables all set.
// - Clock source 0 counts instruction cycles, system clock over four, prescaled.
// - Clock source 1 counts rising edges of the external clock pin, or of the low-power oscillator when it is active, prescaled.
// - External mode counts no rising edge before a falling edge was seen.
// - Sync-disable 0 aligns external edges to instruction cycles; 1 bypasses that.
// - Prescale field 00/01/10/11 divides by 1/2/4/8.
// - Writing either count byte clears the hidden prescale counter.
// - Run bit 0 stops counting; run bit 1 enables it.
// - With gate enable set, count only while gate inactive; else free.
// - Gate source select picks gate pin or comparator 2 output.
// - Gate invert flips the selected gate, whatever its source.
// - Gating applies in both internal timing and external counting.
// - Low-power oscillator runs only with internal oscillator mode and enable set.
// - Unsynchronised external counting continues in sleep and can wake.
// - Each count byte read returns a valid value; rollover between reads possible.
`timescale 1ns/1ps
`default_nettype none
module gtc_timer
  import gtc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        extClockPin,
  input  wire logic        lpOscClk,
  input  wire logic        gatePin,
  input  wire logic        comparator2Output,
  input  wire logic        intoscNoClkout,
  input  wire logic        sleepMode,
  output logic             irqOut,
  output logic             wakeOut,
  output logic             lpOscRun
);
  // Register state
  logic [7:0]  ctl_r;
  logic [7:0]  cmp2_r;
  logic [7:0]  intc_r;
  logic [7:0]  ena_r;
  logic        flag_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [31:0] hrdata_r;
  logic        irq_r;
  logic        wake_r;
  logic        lpRun_r;
  // Bus data phase
  logic        wrPend_r;
  logic [7:0]  wrAddr_r;
  // Timing state
  logic [1:0]  instrCnt_r;
  logic        extPrev_r;
  logic        syncPend_r;
  gtc_arm_t    arm_r;
  gtc_arm_t    arm_nxt;

  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinClean;

  gtc_psc_if psc ();

  gtc_pin_sync u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .pinIn   (pinRaw),
    .pinOut  (pinClean)
  );

  gtc_prescaler u_psc (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .psc     (psc.psc)
  );

  assign pinRaw[PIN_EXT]  = extClockPin;
  assign pinRaw[PIN_LP]   = lpOscClk;
  assign pinRaw[PIN_GATE] = gatePin;
  assign pinRaw[PIN_CMP2] = comparator2Output;

  // Address decode shared by read and write paths
  function automatic logic [6:0] regSel(input logic [7:0] a);
    regSel = {a == OFF_INTR_CTL, a == OFF_CMP2_CTLB, a == OFF_COUNT_CTL, a == OFF_PERIPH_ENA,
              a == OFF_PERIPH_FLG, a == OFF_COUNT_HIGH, a == OFF_COUNT_LOW};
  endfunction

  // Control fields
  wire runBit    = ctl_r[CTL_RUN];
  wire extSel    = ctl_r[CTL_CLK_SRC];
  wire syncDis   = ctl_r[CTL_SYNC_DIS];
  wire lpEnable  = ctl_r[CTL_LP_OSC];
  wire gateEn    = ctl_r[CTL_GATE_EN];
  wire gateInv   = ctl_r[CTL_GATE_INV];
  wire gateSrc   = cmp2_r[CMP2_GATE_SS];
  wire asyncMode = extSel & syncDis;

  // Bus address phase
  wire        addrPhase = hsel & htrans[1] & hready;
  wire        busWrite  = addrPhase & hwrite;
  wire        busRead   = addrPhase & ~hwrite;
  wire [31:0] upperAddr = {haddr[31:8], 8'h00};
  wire        inRange   = (upperAddr == 32'h0000_0000);
  wire [6:0]  rdSel     = inRange ? regSel(haddr[7:0]) : 7'h00;
  wire [6:0]  wrSel     = wrPend_r ? regSel(wrAddr_r) : 7'h00;
  wire [7:0]  wrByte    = hwdata[7:0];

  wire wrCountLow  = wrSel[0];
  wire wrCountHigh = wrSel[1];
  wire wrFlag      = wrSel[2];
  wire wrEna       = wrSel[3];
  wire wrCtl       = wrSel[4];
  wire wrCmp2      = wrSel[5];
  wire wrIntc      = wrSel[6];

  // Read data, narrow registers in low bits; unmapped reads zero
  wire [7:0] rdByte =
      ({8{rdSel[0]}} & count_r[7:0]) |
      ({8{rdSel[1]}} & count_r[15:8]) |
      ({8{rdSel[2]}} & {7'h00, flag_r}) |
      ({8{rdSel[3]}} & ena_r) |
      ({8{rdSel[4]}} & ctl_r) |
      ({8{rdSel[5]}} & cmp2_r) |
      ({8{rdSel[6]}} & intc_r);

  // Sleep stops the instruction clock; only the unsynchronised counter keeps going
  wire instrTick = (instrCnt_r == INSTR_LAST) & ~sleepMode;

  // Counter input clock, low-power oscillator taking over the external input
  wire lpActive = intoscNoClkout & lpEnable;
  wire extLevel = lpActive ? pinClean[PIN_LP] : pinClean[PIN_EXT];
  wire extRise  = extLevel & ~extPrev_r;
  wire extFall  = ~extLevel & extPrev_r;
  wire extEdge  = extRise & (arm_r == ARM_READY);

  // Synchronised mode releases an edge on the next instruction cycle
  wire syncTick = syncPend_r & instrTick;
  wire extTick  = syncDis ? extEdge : syncTick;
  // Asynchronous counting runs through sleep
  wire srcTick  = extSel ? (extTick & (~sleepMode | asyncMode)) : instrTick;

  // Gate: low is active before inversion
  wire gateRaw    = gateSrc ? pinClean[PIN_CMP2] : pinClean[PIN_GATE];
  wire gateActive = ~(gateRaw ^ gateInv);
  wire gateOpen   = ~gateEn | ~gateActive;
  wire countOn    = runBit & gateOpen;

  assign psc.tick  = srcTick & countOn;
  assign psc.clr   = wrCountLow | wrCountHigh;
  assign psc.ratio = ctl_r[CTL_PS_HI:CTL_PS_LO];

  wire incr     = psc.pulse;
  wire rollover = incr & (count_r == COUNT_MAX);

  // Software write wins over a coincident increment
  always_comb begin
    count_nxt = incr ? count_r + 16'h0001 : count_r;
    if (wrCountLow) begin
      count_nxt = {count_r[15:8], wrByte};
    end
    if (wrCountHigh) begin
      count_nxt = {wrByte, count_r[7:0]};
    end
  end

  // Arming waits for a falling edge whenever external counting is idle
  always_comb begin
    arm_nxt = arm_r;
    case (arm_r)
      ARM_WAIT: begin
        if (extFall) begin
          arm_nxt = ARM_READY;
        end
      end
      ARM_READY: begin
        if (!extSel || !runBit) begin
          arm_nxt = ARM_WAIT;
        end
      end
      default: begin
        arm_nxt = ARM_WAIT;
      end
    endcase
  end

  wire flagSet = rollover;
  wire flagNxt = flagSet | (wrFlag ? wrByte[FLG_ROLLOVER] : flag_r);
  wire irqPath = flag_r & ena_r[ENA_ROLLOVER] & intc_r[INTC_PERIPH];

  // Bus slave pipeline; zero wait states, data phase holds the write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      wrPend_r <= busWrite & inRange;
      wrAddr_r <= haddr[7:0];
      if (busRead) begin
        hrdata_r <= {24'h000000, rdByte};
      end
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r  <= CTL_RST;
      cmp2_r <= CMP2_RST;
      intc_r <= INTC_RST;
      ena_r  <= ENA_RST;
    end else if (clk_en) begin
      if (wrCtl) begin
        ctl_r <= wrByte;
      end
      if (wrCmp2) begin
        cmp2_r <= wrByte;
      end
      if (wrIntc) begin
        intc_r <= wrByte;
      end
      if (wrEna) begin
        ena_r <= wrByte;
      end
    end
  end

  // Count, flag and interrupt outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= COUNT_RST;
      flag_r  <= 1'b0;
      irq_r   <= 1'b0;
      wake_r  <= 1'b0;
      lpRun_r <= 1'b0;
    end else if (clk_en) begin
      count_r <= count_nxt;
      flag_r  <= flagNxt;
      irq_r   <= irqPath & intc_r[INTC_GLOBAL];
      // Wake needs no global enable; the processor resumes either way
      wake_r  <= irqPath & sleepMode;
      lpRun_r <= lpActive;
    end
  end

  // Edge tracking and instruction phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      instrCnt_r <= 2'h0;
      extPrev_r  <= 1'b0;
      syncPend_r <= 1'b0;
      arm_r      <= ARM_WAIT;
    end else if (clk_en) begin
      instrCnt_r <= (instrCnt_r == INSTR_LAST) ? 2'h0 : instrCnt_r + 2'h1;
      extPrev_r  <= extLevel;
      arm_r      <= arm_nxt;
      // An edge waiting for alignment is held until the instruction cycle takes it
      if (extEdge && !syncDis) begin
        syncPend_r <= 1'b1;
      end else if (syncTick || syncDis || !extSel) begin
        syncPend_r <= 1'b0;
      end
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irqOut    = irq_r;
  assign wakeOut   = wake_r;
  assign lpOscRun  = lpRun_r;
endmodule
`default_nettype wire

/* core/gtc_unused_placeholder_none.sv */
// Intentionally empty compile unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* dv/gtc_pin_model.sv */
// Pin-side model: external count clock, gate pin and comparator output
`timescale 1ns/1ps
`default_nettype none
module gtc_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [7:0] nEdges,
  input  wire logic       gateLvl,
  input  wire logic       cmpLvl,
  output logic            clkPin,
  output logic            gatePin,
  output logic            cmpOut,
  output logic            busy
);
  logic [8:0] halves;
  logic [1:0] div;
  // Clock stands high between bursts, so each burst opens with a falling edge
  initial begin
    clkPin = 1'b1;
    halves = 9'h000;
    div = 2'h0;
  end
  assign busy = halves != 9'h000;
  assign gatePin = gateLvl;
  assign cmpOut = cmpLvl;
  // Half periods of four system cycles leave the input filter room to agree
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      halves <= {nEdges, 1'b0};
      div <= 2'h0;
    end else if (busy) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        clkPin <= !clkPin;
        halves <= halves - 9'h001;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/gtc_timer_sva.sv */
// Port-level assertions for the gated 16-bit timer counter
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_sva
  import gtc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        intoscNoClkout,
  input wire logic        sleepMode,
  input wire logic        irqOut,
  input wire logic        wakeOut,
  input wire logic        lpOscRun
);
  // Shadows of the control registers, updated where the slave commits a write
  logic       wrData_r;
  logic [7:0] wrAddr_r;
  logic [7:0] shCtl_r;
  logic [7:0] shEna_r;
  logic [7:0] shIntc_r;
  wire        addrOk = hsel && htrans[1] && hready && clk_en && haddr[31:8] == 24'h0;
  wire        rdCtl  = addrOk && !hwrite && haddr[7:0] == OFF_COUNT_CTL;
  wire        rdVoid = addrOk && !hwrite && haddr[7:0] == 8'h1c;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrData_r <= 1'b0;
      wrAddr_r <= 8'h00;
      shCtl_r  <= CTL_RST;
      shEna_r  <= ENA_RST;
      shIntc_r <= INTC_RST;
    end else if (clk_en) begin
      wrData_r <= addrOk && hwrite;
      wrAddr_r <= haddr[7:0];
      if (wrData_r && wrAddr_r == OFF_COUNT_CTL) shCtl_r <= hwdata[7:0];
      if (wrData_r && wrAddr_r == OFF_PERIPH_ENA) shEna_r <= hwdata[7:0];
      if (wrData_r && wrAddr_r == OFF_INTR_CTL) shIntc_r <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  ready_always_a: assert property (hreadyout) else $error("slave inserted a wait state");
  resp_okay_a: assert property (!hresp) else $error("slave answered with an error");
  read_ctl_a: assert property (rdCtl |=> hrdata == {24'h0, $past(shCtl_r)}) else $error("control readback wrong");
  read_void_a: assert property (rdVoid |=> hrdata == 32'h0) else $error("unmapped read not zero");
  irq_enable_a: assert property (irqOut |-> $past(shEna_r[0] && shIntc_r[6] && shIntc_r[7]))
    else $error("interrupt raised while masked");
  irq_hold_a: assert property (irqOut && !$past(wrData_r) |=> irqOut)
    else $error("interrupt dropped without a write");
  wake_cause_a: assert property (wakeOut |-> $past(shEna_r[0] && shIntc_r[6] && sleepMode))
    else $error("wake raised without its enables");
  lposc_follow_a: assert property (lpOscRun == $past(intoscNoClkout && shCtl_r[3]))
    else $error("oscillator run state wrong");
endmodule
bind gtc_timer gtc_timer_sva u_sva (.*);
`default_nettype wire

/* dv/gtc_timer_tb.sv */
// Self-checking bench for the gated 16-bit timer counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module gtc_timer_tb;
  import gtc_pkg::*;
  logic        ref_clk, arst_n, hsel, hwrite, sleepMode, intoscNoClkout, go, gateLvl, cmpLvl, clkEn;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [7:0]  nEdges, rv;
  logic        hreadyout, hresp, irqOut, wakeOut, lpOscRun, clkPin, gatePin, cmpOut, busy;
  int          failures = 0;
  int          check_count = 0;
  // Gate table: control, comparator control, pin level, comparator level, expected count
  logic [31:0] tbl [9] = '{32'h03020004, 32'h43021000, 32'h43020104, 32'hc3020100, 32'h43000100,
                           32'hc3000104, 32'h41021000, 32'h07020004, 32'h02020000};
  gtc_timer DUT (.ref_clk, .arst_n, .clk_en(clkEn), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .extClockPin(clkPin), .lpOscClk(clkPin), .gatePin,
    .comparator2Output(cmpOut), .intoscNoClkout, .sleepMode, .irqOut, .wakeOut, .lpOscRun);
  gtc_pin_model pins (.ref_clk, .go, .nEdges, .gateLvl, .cmpLvl, .clkPin, .gatePin, .cmpOut, .busy);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rv = hrdata[7:0];
  endtask
  task automatic burst(input logic [7:0] n);
    int k;
    go <= 1'b1;
    nEdges <= n;
    @(posedge ref_clk);
    go <= 1'b0;
    k = 0;
    @(negedge ref_clk);
    while (busy && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    `CHK("burst end", 1'b0, busy)
    repeat (16) @(posedge ref_clk);
  endtask
  task automatic clear_count;
    xfer(1'b1, OFF_COUNT_LOW, 8'h00);
    xfer(1'b1, OFF_COUNT_HIGH, 8'h00);
  endtask
  task automatic t_regs;
    logic [7:0] adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    logic [7:0] rst [8] = '{8'h00, 8'h00, 8'h00, ENA_RST, CTL_RST, CMP2_RST, INTC_RST, 8'h00};
    foreach (adr[i]) begin
      xfer(1'b0, adr[i], 8'h00);
      `CHK("reset value", rst[i], rv)
    end
    xfer(1'b1, OFF_COUNT_CTL, 8'ha4);
    xfer(1'b0, OFF_COUNT_CTL, 8'h00);
    `CHK("control readback", 8'ha4, rv)
    xfer(1'b1, OFF_COUNT_CTL, 8'h00);
  endtask
  task automatic t_prescale;
    int ex;
    logic [7:0] a;
    for (int ps = 0; ps < 4; ps++) begin
      clear_count();
      xfer(1'b1, OFF_COUNT_CTL, {2'b00, 2'(ps), 4'h1});
      repeat (125) @(posedge ref_clk);
      xfer(1'b1, OFF_COUNT_CTL, 8'h00);
      xfer(1'b0, OFF_COUNT_LOW, 8'h00);
      a = rv;
      ex = 32 >> ps;
      `CHK("prescaled count", 1'b1, (a + 1 >= ex && a <= ex + 1))
      repeat (20) @(posedge ref_clk);
      xfer(1'b0, OFF_COUNT_LOW, 8'h00);
      `CHK("stopped count", a, rv)
    end
  endtask
  // Clock enable low must freeze the counter and its instruction phase alike
  task automatic t_freeze;
    logic [7:0] a;
    clear_count();
    xfer(1'b1, OFF_COUNT_CTL, 8'h01);
    repeat (20) @(posedge ref_clk);
    xfer(1'b0, OFF_COUNT_LOW, 8'h00);
    a = rv;
    clkEn <= 1'b0;
    repeat (40) @(posedge ref_clk);
    clkEn <= 1'b1;
    xfer(1'b0, OFF_COUNT_LOW, 8'h00);
    `CHK("frozen count", 1'b1, 8'(rv - a) <= 8'h01)
    xfer(1'b1, OFF_COUNT_CTL, 8'h00);
  endtask
  task automatic t_roll;
    xfer(1'b1, OFF_PERIPH_FLG, 8'h00);
    xfer(1'b1, OFF_COUNT_LOW, 8'hfe);
    xfer(1'b1, OFF_COUNT_HIGH, 8'hff);
    xfer(1'b1, OFF_PERIPH_ENA, 8'h01);
    xfer(1'b1, OFF_INTR_CTL, 8'hc0);
    xfer(1'b1, OFF_COUNT_CTL, 8'h01);
    repeat (60) @(posedge ref_clk);
    xfer(1'b1, OFF_COUNT_CTL, 8'h00);
    xfer(1'b0, OFF_COUNT_HIGH, 8'h00);
    `CHK("high byte after wrap", 8'h00, rv)
    xfer(1'b0, OFF_PERIPH_FLG, 8'h00);
    `CHK("flag after wrap", 8'h01, rv)
    `CHK("irq enabled", 1'b1, irqOut)
    xfer(1'b1, OFF_INTR_CTL, 8'h40);
    repeat (3) @(posedge ref_clk);
    `CHK("irq without global", 1'b0, irqOut)
    xfer(1'b1, OFF_INTR_CTL, 8'hc0);
    repeat (3) @(posedge ref_clk);
    `CHK("flag kept set", 1'b1, irqOut)
    xfer(1'b1, OFF_PERIPH_FLG, 8'h00);
    repeat (3) @(posedge ref_clk);
    `CHK("irq after clear", 1'b0, irqOut)
  endtask
  task automatic t_gate;
    foreach (tbl[i]) begin
      xfer(1'b1, OFF_COUNT_CTL, 8'h00);
      clear_count();
      // Levels go first so the filtered gate settles before the run bit lands
      gateLvl <= tbl[i][12];
      cmpLvl <= tbl[i][8];
      sleepMode <= tbl[i][26];
      xfer(1'b1, OFF_CMP2_CTLB, tbl[i][23:16]);
      xfer(1'b1, OFF_COUNT_CTL, tbl[i][31:24]);
      repeat (12) @(posedge ref_clk);
      burst(8'd4);
      xfer(1'b0, OFF_COUNT_LOW, 8'h00);
      `CHK("gated count", tbl[i][7:0], rv)
      sleepMode <= 1'b0;
    end
  endtask
  task automatic t_psclr;
    xfer(1'b1, OFF_COUNT_CTL, 8'h00);
    clear_count();
    xfer(1'b1, OFF_COUNT_CTL, 8'h33);
    burst(8'd4);
    xfer(1'b1, OFF_COUNT_LOW, 8'h00);
    burst(8'd4);
    xfer(1'b0, OFF_COUNT_LOW, 8'h00);
    `CHK("prescaler cleared", 8'h00, rv)
    burst(8'd8);
    xfer(1'b0, OFF_COUNT_LOW, 8'h00);
    `CHK("count after clear", 8'h01, rv)
  endtask
  task automatic t_wake;
    xfer(1'b1, OFF_COUNT_CTL, 8'h00);
    xfer(1'b1, OFF_COUNT_LOW, 8'hfe);
    xfer(1'b1, OFF_COUNT_HIGH, 8'hff);
    xfer(1'b1, OFF_INTR_CTL, 8'h40);
    sleepMode <= 1'b1;
    xfer(1'b1, OFF_COUNT_CTL, 8'h07);
    burst(8'd4);
    `CHK("wake in sleep", 1'b1, wakeOut)
    `CHK("irq masked", 1'b0, irqOut)
    xfer(1'b0, OFF_COUNT_LOW, 8'h00);
    `CHK("async low byte", 8'h02, rv)
    sleepMode <= 1'b0;
    xfer(1'b1, OFF_COUNT_CTL, 8'h00);
    intoscNoClkout <= 1'b1;
    xfer(1'b1, OFF_COUNT_CTL, 8'h08);
    repeat (3) @(posedge ref_clk);
    `CHK("osc running", 1'b1, lpOscRun)
    intoscNoClkout <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("osc ignored", 1'b0, lpOscRun)
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Whole run is under two thousand cycles; the limit leaves a wide margin
  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    close_out();
  end
  initial begin
    {arst_n, hsel, hwrite, sleepMode, intoscNoClkout, go, gateLvl, cmpLvl} = 8'h00;
    {haddr, hwdata, htrans, nEdges} = 74'h0;
    clkEn = 1'b1;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_prescale();
    t_freeze();
    t_roll();
    t_gate();
    t_psclr();
    t_wake();
    close_out();
  end
endmodule
`default_nettype wire
